/* File: verilog/fvic_pkg.sv */
// Package: constants, offsets and types of the four vector interrupt control
package fvic_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int PC_W = 16;
   localparam int PERIPH_W = 8;
   localparam int EV_W = 5;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CPU_STATUS_OFS = 8'h06;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h07;
   localparam logic [ADDR_W-1:0] PERIPH_FLAG_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] PERIPH_ENABLE_OFS = 8'h09;
   localparam logic [ADDR_W-1:0] EVENT_STATUS_OFS = 8'h0A;
   localparam logic [ADDR_W-1:0] EVENT_MASK_OFS = 8'h0B;
   localparam logic [ADDR_W-1:0] EDGE_CTRL_OFS = 8'h0C;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int GID_BIT = 4;
   localparam int ST_PERIPH_FLAG = 7;
   localparam int ST_TCK_FLAG = 6;
   localparam int ST_T0_FLAG = 5;
   localparam int ST_EXT_FLAG = 4;
   localparam int ST_PERIPH_EN = 3;
   localparam int ST_TCK_EN = 2;
   localparam int ST_T0_EN = 1;
   localparam int ST_EXT_EN = 0;
   localparam int EV_TAKE_EXT = 0;
   localparam int EV_TAKE_T0 = 1;
   localparam int EV_TAKE_TCK = 2;
   localparam int EV_TAKE_PERIPH = 3;
   localparam int EV_RETURN = 4;
   localparam int EDGE_EXT_BIT = 0;
   localparam int EDGE_TCK_BIT = 1;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic GID_RST = 1'b1;
   localparam logic [3:0] IRQ_ENABLE_RST = 4'h0;
   localparam logic [2:0] IRQ_FLAG_RST = 3'h0;
   localparam logic [PERIPH_W-1:0] PERIPH_FLAG_RST = 8'h00;
   localparam logic [PERIPH_W-1:0] PERIPH_ENABLE_RST = 8'h00;
   localparam logic [EV_W-1:0] EVENT_STATUS_RST = 5'h00;
   localparam logic [EV_W-1:0] EVENT_MASK_RST = 5'h00;
   localparam logic [1:0] EDGE_CTRL_RST = 2'h3;

   // ----------------------------------------------------------------
   // Vector addresses
   // ----------------------------------------------------------------
   localparam logic [PC_W-1:0] VEC_EXT = 16'h0008;
   localparam logic [PC_W-1:0] VEC_T0 = 16'h0010;
   localparam logic [PC_W-1:0] VEC_TCK = 16'h0018;
   localparam logic [PC_W-1:0] VEC_PERIPH = 16'h0020;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SRC_NONE = 3'b000,
      SRC_EXT = 3'b001,
      SRC_T0 = 3'b010,
      SRC_TCK = 3'b011,
      SRC_PERIPH = 3'b100
   } fvic_src_e;

   typedef struct packed {
      logic [PC_W-1:0] vector_addr;
      logic [PC_W-1:0] return_addr;
      fvic_src_e source;
   } fvic_vector_s;

endpackage : fvic_pkg

/* File: verilog/fvic_flag.sv */
// Sticky flag bits: hardware set beats software load and clear
`timescale 1ns/10ps
module fvic_flag #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] set_i,
   input wire logic load_i,
   input wire logic [W-1:0] load_val_i,
   input wire logic [W-1:0] clr_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   // Set is ORed last so an event in a clearing cycle is never lost
   always_comb begin
      q_next = load_i ? load_val_i : (q_reg & ~clr_i);
      q_next = q_next | set_i;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_reg <= RST_VAL;
      end else begin
         q_reg <= q_next;
      end
   end

   assign q_o = q_reg;

endmodule : fvic_flag

/* File: verilog/fvic_pin_sync.sv */
// Pin synchroniser with agreement filter and selectable edge detect
`timescale 1ns/10ps
module fvic_pin_sync (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic pin_i,
   input wire logic rise_sel_i,
   output logic edge_o
);

   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_reg;
   logic agree;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A change counts only once stages two and three agree
   assign agree = (s2_reg == s3_reg);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_reg <= 1'b0;
      end else if (agree) begin
         level_reg <= s3_reg;
      end
   end

   assign edge_o = agree && (s3_reg != level_reg) && (s3_reg == rise_sel_i);

endmodule : fvic_pin_sync

/* File: verilog/fvic_core.sv */
// Four vector interrupt control: flags, enables, priority and vectoring
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/10ps
module fvic_core
   import fvic_pkg::*;
(
   input wire logic CORE_CLK_I,
   input wire logic RESET_N_I,
   input wire logic [ADDR_W-1:0] REG_ADDR_I,
   input wire logic [DATA_W-1:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [DATA_W-1:0] REG_RDATA_O,
   input wire logic EXT_IRQ_PIN_I,
   input wire logic TIMER_CLOCK_PIN_I,
   input wire logic TIMER0_OVERFLOW_I,
   input wire logic [PERIPH_W-1:0] PERIPH_EVENT_I,
   input wire logic INSTR_BOUNDARY_I,
   input wire logic RETURN_FROM_IRQ_INSTR_I,
   input wire logic [PC_W-1:0] RETURN_ADDR_I,
   output logic IRQ_PENDING_O,
   output logic VECTOR_TAKE_O,
   output fvic_vector_s VECTOR_O,
   output logic GLOBAL_IRQ_DISABLE_O,
   output logic IRQ_O
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic global_irq_disable_reg;
   logic [3:0] irq_enable_reg;
   logic [1:0] edge_ctrl_reg;
   logic [EV_W-1:0] event_mask_reg;
   logic [PERIPH_W-1:0] periph_enable_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic take_reg;
   fvic_vector_s vector_reg;

   logic [2:0] irq_flag;
   logic [2:0] irq_flag_set;
   logic [2:0] irq_flag_clr;
   logic [PERIPH_W-1:0] periph_flag;
   logic [EV_W-1:0] event_status;
   logic [EV_W-1:0] event_set;
   logic [EV_W-1:0] event_clr;

   logic ext_pin_edge;
   logic timer_clock_pin_edge;
   logic ext_pin_irq_flag;
   logic timer0_overflow_flag;
   logic timer_clock_pin_flag;
   logic periph_group_flag;
   logic ext_pin_irq_enable;
   logic timer0_overflow_enable;
   logic timer_clock_pin_enable;
   logic periph_group_enable;
   logic req_ext;
   logic req_t0;
   logic req_tck;
   logic req_periph;
   logic irq_pending;
   logic take;
   fvic_src_e take_src;
   logic [PC_W-1:0] take_addr;

   logic wr_cpu_status;
   logic wr_irq_status;
   logic wr_periph_flag;
   logic wr_periph_enable;
   logic wr_event_mask;
   logic wr_edge_ctrl;
   logic rd_event_status;

   // ----------------------------------------------------------------
   // Register port decode
   // ----------------------------------------------------------------
   assign wr_cpu_status = REG_WR_I && (REG_ADDR_I == CPU_STATUS_OFS);
   assign wr_irq_status = REG_WR_I && (REG_ADDR_I == IRQ_STATUS_OFS);
   assign wr_periph_flag = REG_WR_I && (REG_ADDR_I == PERIPH_FLAG_OFS);
   assign wr_periph_enable = REG_WR_I && (REG_ADDR_I == PERIPH_ENABLE_OFS);
   assign wr_event_mask = REG_WR_I && (REG_ADDR_I == EVENT_MASK_OFS);
   assign wr_edge_ctrl = REG_WR_I && (REG_ADDR_I == EDGE_CTRL_OFS);
   assign rd_event_status = REG_RD_I && (REG_ADDR_I == EVENT_STATUS_OFS);

   // ----------------------------------------------------------------
   // Pin inputs
   // ----------------------------------------------------------------
   fvic_pin_sync u_ext_pin_sync (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RESET_N_I),
      .pin_i(EXT_IRQ_PIN_I),
      .rise_sel_i(edge_ctrl_reg[EDGE_EXT_BIT]),
      .edge_o(ext_pin_edge)
   );

   fvic_pin_sync u_tck_pin_sync (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RESET_N_I),
      .pin_i(TIMER_CLOCK_PIN_I),
      .rise_sel_i(edge_ctrl_reg[EDGE_TCK_BIT]),
      .edge_o(timer_clock_pin_edge)
   );

   // ----------------------------------------------------------------
   // Interrupt flags
   // ----------------------------------------------------------------
   // Events set flags with no regard to any enable
   assign irq_flag_set = {timer_clock_pin_edge, TIMER0_OVERFLOW_I,
                          ext_pin_edge};
   // Only timer0 is cleared by vectoring; pin flags stay for software
   assign irq_flag_clr = {1'b0, take && (take_src == SRC_T0),
                          1'b0};

   fvic_flag #(
      .W(3),
      .RST_VAL(IRQ_FLAG_RST)
   ) u_irq_flag (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RESET_N_I),
      .set_i(irq_flag_set),
      .load_i(wr_irq_status),
      .load_val_i(REG_WDATA_I[ST_TCK_FLAG:ST_EXT_FLAG]),
      .clr_i(irq_flag_clr),
      .q_o(irq_flag)
   );

   assign ext_pin_irq_flag = irq_flag[0];
   assign timer0_overflow_flag = irq_flag[1];
   assign timer_clock_pin_flag = irq_flag[2];

   // Hardware never clears these; service software must do it
   fvic_flag #(
      .W(PERIPH_W),
      .RST_VAL(PERIPH_FLAG_RST)
   ) u_periph_flag (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RESET_N_I),
      .set_i(PERIPH_EVENT_I),
      .load_i(wr_periph_flag),
      .load_val_i(REG_WDATA_I),
      .clr_i('0),
      .q_o(periph_flag)
   );

   assign periph_group_flag = |(periph_flag & periph_enable_reg);

   // ----------------------------------------------------------------
   // Enables and edge control
   // ----------------------------------------------------------------
   // Software should raise global disable first, since a request seen in
   // the same cycle as the enable write may still be taken
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         irq_enable_reg <= IRQ_ENABLE_RST;
      end else if (wr_irq_status) begin
         irq_enable_reg <= REG_WDATA_I[ST_PERIPH_EN:ST_EXT_EN];
      end
   end

   assign ext_pin_irq_enable = irq_enable_reg[ST_EXT_EN];
   assign timer0_overflow_enable = irq_enable_reg[ST_T0_EN];
   assign timer_clock_pin_enable = irq_enable_reg[ST_TCK_EN];
   assign periph_group_enable = irq_enable_reg[ST_PERIPH_EN];

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         periph_enable_reg <= PERIPH_ENABLE_RST;
      end else if (wr_periph_enable) begin
         periph_enable_reg <= REG_WDATA_I;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         edge_ctrl_reg <= EDGE_CTRL_RST;
      end else if (wr_edge_ctrl) begin
         edge_ctrl_reg <= REG_WDATA_I[1:0];
      end
   end

   // ----------------------------------------------------------------
   // Request qualification and priority
   // ----------------------------------------------------------------
   assign req_ext = ext_pin_irq_flag && ext_pin_irq_enable;
   assign req_t0 = timer0_overflow_flag && timer0_overflow_enable;
   assign req_tck = timer_clock_pin_flag && timer_clock_pin_enable;
   assign req_periph = periph_group_flag && periph_group_enable;

   assign irq_pending = (req_ext || req_t0 || req_tck || req_periph)
                        && !global_irq_disable_reg;
   // Taking only at a boundary lets the current instruction finish
   assign take = irq_pending && INSTR_BOUNDARY_I;

   always_comb begin
      take_src = SRC_NONE;
      take_addr = VEC_PERIPH;
      if (req_ext) begin
         take_src = SRC_EXT;
         take_addr = VEC_EXT;
      end else if (req_t0) begin
         take_src = SRC_T0;
         take_addr = VEC_T0;
      end else if (req_tck) begin
         take_src = SRC_TCK;
         take_addr = VEC_TCK;
      end else if (req_periph) begin
         take_src = SRC_PERIPH;
         take_addr = VEC_PERIPH;
      end
   end

   // ----------------------------------------------------------------
   // Global interrupt disable
   // ----------------------------------------------------------------
   // Acceptance beats a software clear in the same cycle, so a set that
   // races an interrupt is never undone behind software's back
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         global_irq_disable_reg <= GID_RST;
      end else if (take) begin
         global_irq_disable_reg <= 1'b1;
      end else if (wr_cpu_status) begin
         global_irq_disable_reg <= REG_WDATA_I[GID_BIT];
      end else if (RETURN_FROM_IRQ_INSTR_I) begin
         global_irq_disable_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Vector hand-off to the sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         take_reg <= 1'b0;
      end else begin
         take_reg <= take;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         vector_reg <= '{vector_addr: 16'h0000, return_addr: 16'h0000,
                         source: SRC_NONE};
      end else if (take) begin
         vector_reg <= '{vector_addr: take_addr,
                         return_addr: RETURN_ADDR_I,
                         source: take_src};
      end
   end

   // ----------------------------------------------------------------
   // Event status, mask and interrupt output
   // ----------------------------------------------------------------
   always_comb begin
      event_set = '0;
      event_set[EV_TAKE_EXT] = take && (take_src == SRC_EXT);
      event_set[EV_TAKE_T0] = take && (take_src == SRC_T0);
      event_set[EV_TAKE_TCK] = take && (take_src == SRC_TCK);
      event_set[EV_TAKE_PERIPH] = take && (take_src == SRC_PERIPH);
      event_set[EV_RETURN] = RETURN_FROM_IRQ_INSTR_I;
   end

   assign event_clr = rd_event_status ? {EV_W{1'b1}} : '0;

   fvic_flag #(
      .W(EV_W),
      .RST_VAL(EVENT_STATUS_RST)
   ) u_event_status (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RESET_N_I),
      .set_i(event_set),
      .load_i(1'b0),
      .load_val_i('0),
      .clr_i(event_clr),
      .q_o(event_status)
   );

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         event_mask_reg <= EVENT_MASK_RST;
      end else if (wr_event_mask) begin
         event_mask_reg <= REG_WDATA_I[EV_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_comb begin
      rdata_next = '0;
      unique case (REG_ADDR_I)
         CPU_STATUS_OFS: begin
            rdata_next[GID_BIT] = global_irq_disable_reg;
         end
         IRQ_STATUS_OFS: begin
            rdata_next = {periph_group_flag, timer_clock_pin_flag,
                          timer0_overflow_flag, ext_pin_irq_flag,
                          irq_enable_reg};
         end
         PERIPH_FLAG_OFS: begin
            rdata_next = periph_flag;
         end
         PERIPH_ENABLE_OFS: begin
            rdata_next = periph_enable_reg;
         end
         EVENT_STATUS_OFS: begin
            rdata_next[EV_W-1:0] = event_status;
         end
         EVENT_MASK_OFS: begin
            rdata_next[EV_W-1:0] = event_mask_reg;
         end
         EDGE_CTRL_OFS: begin
            rdata_next[1:0] = edge_ctrl_reg;
         end
         default: begin
            rdata_next = '0;
         end
      endcase
   end

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rdata_reg <= '0;
      end else if (REG_RD_I) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= '0;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign REG_RDATA_O = rdata_reg;
   assign IRQ_PENDING_O = irq_pending;
   assign VECTOR_TAKE_O = take_reg;
   assign VECTOR_O = vector_reg;
   assign GLOBAL_IRQ_DISABLE_O = global_irq_disable_reg;
   assign IRQ_O = |(event_status & event_mask_reg);

endmodule : fvic_core

/* File: sim/fvic_cpu_model.sv */
// Partner: core sequencer model giving boundaries and return addresses
`timescale 1ns/10ps
module fvic_cpu_model
   import fvic_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] mode_i,
   input wire logic take_i,
   input wire fvic_vector_s vec_i,
   output logic boundary_o,
   output logic [PC_W-1:0] ret_addr_o
);
   logic [1:0] cnt_reg;
   logic [PC_W-1:0] pc_reg;

   // Mode 0 prompt, 1 every fourth cycle, 2 stuck in a long instruction
   assign boundary_o = (mode_i == 2'h0) ||
      (mode_i == 2'h1 && cnt_reg == 2'h0);
   assign ret_addr_o = pc_reg;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= 2'h0;
         pc_reg <= 16'h0100;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
         // Push is implied: the return address left on the bus is kept
         if (take_i) begin
            pc_reg <= vec_i.vector_addr;
         end else if (boundary_o) begin
            pc_reg <= pc_reg + 16'h0001;
         end
      end
   end
endmodule : fvic_cpu_model

/* File: sim/fvic_core_chk.sv */
// Checker: port level assertions of the interrupt control
`timescale 1ns/10ps
module fvic_core_chk
   import fvic_pkg::*;
(
   input wire logic CORE_CLK_I,
   input wire logic RESET_N_I,
   input wire logic REG_WR_I,
   input wire logic INSTR_BOUNDARY_I,
   input wire logic RETURN_FROM_IRQ_INSTR_I,
   input wire logic [PC_W-1:0] RETURN_ADDR_I,
   input wire logic IRQ_PENDING_O,
   input wire logic VECTOR_TAKE_O,
   input wire fvic_vector_s VECTOR_O,
   input wire logic GLOBAL_IRQ_DISABLE_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESET_N_I);

   // Acceptance condition as the design sees it at the boundary edge
   logic take_seen;
   assign take_seen = INSTR_BOUNDARY_I && IRQ_PENDING_O;

   function automatic logic [PC_W-1:0] vec_of(fvic_src_e s);
      case (s)
         SRC_EXT: return VEC_EXT;
         SRC_T0: return VEC_T0;
         SRC_TCK: return VEC_TCK;
         SRC_PERIPH: return VEC_PERIPH;
         default: return 16'hFFFF;
      endcase
   endfunction : vec_of

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_take;
      INSTR_BOUNDARY_I && IRQ_PENDING_O;
   endsequence
   sequence s_accept;
      VECTOR_TAKE_O && GLOBAL_IRQ_DISABLE_O;
   endsequence

   a_take_accepts: assert property (s_take |=> s_accept)
      else $error("take not accepted");
   a_take_caused: assert property (
      VECTOR_TAKE_O |-> $past(take_seen))
      else $error("take without boundary");
   a_gid_blocks: assert property (
      GLOBAL_IRQ_DISABLE_O |-> !IRQ_PENDING_O ##1 !VECTOR_TAKE_O)
      else $error("pending while disabled");
   a_return_clears: assert property (
      RETURN_FROM_IRQ_INSTR_I && !REG_WR_I && !take_seen |=>
      !GLOBAL_IRQ_DISABLE_O)
      else $error("return left disable set");
   a_vector_map: assert property (
      VECTOR_TAKE_O |-> VECTOR_O.vector_addr == vec_of(VECTOR_O.source))
      else $error("vector does not match source");
   a_vector_holds: assert property (
      !VECTOR_TAKE_O |-> $stable(VECTOR_O))
      else $error("vector moved without take");
   a_take_single: assert property (
      VECTOR_TAKE_O |=> !VECTOR_TAKE_O [*2])
      else $error("second take too soon");
   a_return_addr: assert property (
      VECTOR_TAKE_O |-> VECTOR_O.return_addr == $past(RETURN_ADDR_I))
      else $error("wrong return address");
endmodule : fvic_core_chk

bind fvic_core fvic_core_chk fvic_core_chk_inst (
   .CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .REG_WR_I(REG_WR_I),
   .INSTR_BOUNDARY_I(INSTR_BOUNDARY_I),
   .RETURN_FROM_IRQ_INSTR_I(RETURN_FROM_IRQ_INSTR_I),
   .RETURN_ADDR_I(RETURN_ADDR_I), .IRQ_PENDING_O(IRQ_PENDING_O),
   .VECTOR_TAKE_O(VECTOR_TAKE_O), .VECTOR_O(VECTOR_O),
   .GLOBAL_IRQ_DISABLE_O(GLOBAL_IRQ_DISABLE_O));

/* File: sim/fvic_core_bench.sv */
// Testbench: self-checking scenarios for the interrupt control
`timescale 1ns/10ps
module fvic_core_bench;
   import fvic_pkg::*;
   logic clk, rst_n, wr, rd, ext_pin, tck_pin, t0_ov, ret_pulse;
   logic boundary, pend, take, gid, irq;
   logic [1:0] mode;
   logic [7:0] addr, wdata, rdata, d;
   logic [PERIPH_W-1:0] pev;
   logic [PC_W-1:0] ret_addr;
   fvic_vector_s vec;
   int bad_count, check_count;

   fvic_core fvic_core_inst (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
      .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_RDATA_O(rdata), .EXT_IRQ_PIN_I(ext_pin),
      .TIMER_CLOCK_PIN_I(tck_pin), .TIMER0_OVERFLOW_I(t0_ov),
      .PERIPH_EVENT_I(pev), .INSTR_BOUNDARY_I(boundary),
      .RETURN_FROM_IRQ_INSTR_I(ret_pulse), .RETURN_ADDR_I(ret_addr),
      .IRQ_PENDING_O(pend), .VECTOR_TAKE_O(take), .VECTOR_O(vec),
      .GLOBAL_IRQ_DISABLE_O(gid), .IRQ_O(irq));
   fvic_cpu_model fvic_cpu_model_inst (.clk_i(clk), .rst_n_i(rst_n),
      .mode_i(mode), .take_i(take), .vec_i(vec), .boundary_o(boundary),
      .ret_addr_o(ret_addr));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize
   task automatic wr_reg(input logic [7:0] a, dat);
      @(posedge clk); wr <= 1'b1; addr <= a; wdata <= dat;
      @(posedge clk); wr <= 1'b0;
      #1;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk); rd <= 1'b1; addr <= a;
      @(posedge clk); rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   task automatic wait_take;
      int n;
      n = 0;
      while (take !== 1'b1 && n < 40) begin
         @(posedge clk); #1; n++;
      end
      if (take !== 1'b1) begin
         check("take", take, 1'b1);
         summarize();
      end
   endtask : wait_take
   // Early parts may drop the set, so software reads it back
   task automatic set_gid;
      for (int n = 0; n < 4; n++) begin
         wr_reg(CPU_STATUS_OFS, 8'h10);
         rd_reg(CPU_STATUS_OFS, d);
         if (d[GID_BIT] === 1'b1) break;
      end
      check("gid set", d, 8'h10);
   endtask : set_gid

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      check("gid", gid, 1'b1);
      rd_reg(CPU_STATUS_OFS, d); check("cpu st", d, 8'h10);
      rd_reg(IRQ_STATUS_OFS, d); check("irq st", d, 8'h00);
      rd_reg(EDGE_CTRL_OFS, d); check("edge rst", d, 8'h03);
      rd_reg(8'hFF, d); check("unmapped", d, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_events;
      wr_reg(PERIPH_ENABLE_OFS, 8'h01);
      wr_reg(EVENT_MASK_OFS, 8'h1F);
      @(posedge clk); t0_ov <= 1'b1; pev <= 8'h01;
      ext_pin <= 1'b1; tck_pin <= 1'b1;
      @(posedge clk); t0_ov <= 1'b0; pev <= 8'h00;
      repeat (8) @(posedge clk);
      rd_reg(IRQ_STATUS_OFS, d); check("flags", d, 8'hF0);
      check("pend off", pend, 1'b0);
      rd_reg(PERIPH_FLAG_OFS, d); check("pflag", d, 8'h01);
      wr_reg(PERIPH_ENABLE_OFS, 8'h00);
      rd_reg(IRQ_STATUS_OFS, d); check("group flag", d, 8'h70);
      wr_reg(PERIPH_ENABLE_OFS, 8'h01);
      $display("test events done");
   endtask : t_events
   task automatic t_group;
      @(posedge clk); mode <= 2'h2;
      wr_reg(IRQ_STATUS_OFS, 8'h70);
      wr_reg(CPU_STATUS_OFS, 8'h00);
      check("no enables", pend, 1'b0);
      wr_reg(IRQ_STATUS_OFS, 8'h78);
      check("group on", pend, 1'b1);
      wr_reg(PERIPH_ENABLE_OFS, 8'h00);
      check("own off", pend, 1'b0);
      wr_reg(PERIPH_ENABLE_OFS, 8'h01);
      set_gid();
      check("blocked", pend, 1'b0);
      wr_reg(IRQ_STATUS_OFS, 8'h70);
      $display("test group done");
   endtask : t_group
   // All four pending at once: taken strictly in priority order
   task automatic t_priority;
      logic [15:0] vt[4] = '{VEC_EXT, VEC_T0, VEC_TCK, VEC_PERIPH};
      logic [7:0] fa[4] = '{8'h6F, 8'h4F, 8'h0F, 8'h0F};
      wr_reg(IRQ_STATUS_OFS, 8'h7F);
      rd_reg(EVENT_STATUS_OFS, d); check("ev idle", d, 8'h00);
      wr_reg(CPU_STATUS_OFS, 8'h00);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk); mode <= (i == 1 || i == 3) ? 2'h1 : 2'h0;
         wait_take();
         check("vector", vec.vector_addr, vt[i]);
         check("source", vec.source, 16'(i + 1));
         check("gid take", gid, 1'b1);
         check("irq up", irq, 1'b1);
         @(posedge clk); mode <= 2'h2;
         rd_reg(EVENT_STATUS_OFS, d);
         check("ev", d, (8'h01 << i) | ((i > 0) ? 8'h10 : 8'h00));
         check("irq clr", irq, 1'b0);
         if (i == 1) begin
            rd_reg(IRQ_STATUS_OFS, d); check("t0 auto", d, 8'hCF);
         end
         wr_reg(IRQ_STATUS_OFS, fa[i]);
         if (i == 3) wr_reg(PERIPH_FLAG_OFS, 8'h00);
         @(posedge clk); ret_pulse <= 1'b1;
         @(posedge clk); ret_pulse <= 1'b0;
         #1 check("gid ret", gid, 1'b0);
      end
      check("idle", pend, 1'b0);
      wr_reg(EVENT_MASK_OFS, 8'h00);
      check("masked", irq, 1'b0);
      rd_reg(EVENT_STATUS_OFS, d); check("ev ret", d, 8'h10);
      wr_reg(EVENT_MASK_OFS, 8'h1F);
      check("irq gone", irq, 1'b0);
      $display("test priority done");
   endtask : t_priority
   // Falling edge selection on both pins; pins are high on entry
   task automatic t_edges;
      wr_reg(EDGE_CTRL_OFS, 8'h00);
      rd_reg(EDGE_CTRL_OFS, d); check("edge sel", d, 8'h00);
      @(posedge clk); ext_pin <= 1'b0; tck_pin <= 1'b0;
      repeat (8) @(posedge clk);
      rd_reg(IRQ_STATUS_OFS, d); check("fall flags", d, 8'h5F);
      check("fall pend", pend, 1'b1);
      $display("test edges done");
   endtask : t_edges
   task automatic t_reset_mid;
      @(posedge clk); rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1 check("gid rst", gid, 1'b1);
      check("vec rst", vec.vector_addr, 16'h0000);
      check("take rst", take, 1'b0);
      rd_reg(IRQ_STATUS_OFS, d); check("st rst", d, 8'h00);
      $display("test reset mid done");
   endtask : t_reset_mid

   initial begin
      rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
      ext_pin = 1'b0; tck_pin = 1'b0; t0_ov = 1'b0; pev = 8'h00;
      ret_pulse = 1'b0; mode = 2'h0; bad_count = 0; check_count = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_events();
      t_group();
      t_priority();
      t_edges();
      t_reset_mid();
      summarize();
   end
endmodule : fvic_core_bench
